// >>> lcis_input_select.sv
/*
 logic cell input select, low half: selector register, two channel
 multiplexers, true/inverted gate terms and an AXI4-Lite register slave.
 assumes ref_clk at 200 MHz, nrst is the power-on/brown-out reset, warmRst
 is a synchronous "other" reset from logic on ref_clk, and candidate
 inputs are asynchronous to ref_clk.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module lcis_input_select (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic warmRst,
   input wire logic [lcis_pkg::CAND_N-1:0] candidateInput,
   input wire logic [lcis_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [lcis_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [lcis_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [lcis_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic dataChannelOne_r,
   output logic dataChannelTwo_r,
   output logic [15:0] gateTerm_r
);
   import lcis_pkg::*;

   // selector and enable storage
   logic [SEL_W-1:0] selOne_r;
   logic [SEL_W-1:0] selTwo_r;
   logic [15:0] gateEn_r;

   // candidate synchroniser
   logic [CAND_N-1:0] candMeta_r;
   logic [CAND_N-1:0] candSync_r;

   // write channel state
   logic awHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic wHeld_r;
   logic [DATA_W-1:0] wData_r;
   logic [3:0] wStrb_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;

   // read channel state
   logic arready_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;

   // next values
   logic awHeld_nxt;
   logic wHeld_nxt;
   logic bvalid_nxt;
   logic rvalid_nxt;

   // decode wires
   logic awTake;
   logic wTake;
   logic wrDo;
   logic wrSel;
   logic wrGate;
   logic wrMapped;
   logic arTake;
   logic rdSel;
   logic rdGate;
   logic rdStat;
   logic rdMapped;
   logic [DATA_W-1:0] rdWord;
   logic [DATA_W-1:0] selWord;
   logic [DATA_W-1:0] gateWord;
   logic [DATA_W-1:0] statWord;
   logic [15:0] gateEn_nxt;

   // channel wires
   logic chanOne;
   logic chanTwo;
   logic [15:0] term_nxt;

   lcis_chan_if oneIf ();
   lcis_chan_if twoIf ();

   // candidates come from pins, so two flops before any use
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         candMeta_r <= '0;
         candSync_r <= '0;
      end else begin
         candMeta_r <= candidateInput;
         candSync_r <= candMeta_r;
      end
   end

   // feed both multiplexers from the synchronised set
   assign oneIf.sel = selOne_r;
   assign oneIf.cand = candSync_r;
   assign twoIf.sel = selTwo_r;
   assign twoIf.cand = candSync_r;
   assign chanOne = oneIf.chan;
   assign chanTwo = twoIf.chan;

   // channel one window starts at input 0
   lcis_chan_mux #(.BASE(CH_ONE_BASE)) oneMux (
      .port(oneIf)
   );

   // channel two window starts at input 4
   lcis_chan_mux #(.BASE(CH_TWO_BASE)) twoMux (
      .port(twoIf)
   );

   // true and inverted forms, each gated by its own enable bit; plain operands
   // so the assignment wakes whenever a registered channel moves
   assign term_nxt = {GATE_N{~dataChannelTwo_r, dataChannelTwo_r,
                             ~dataChannelOne_r, dataChannelOne_r}} & gateEn_r;

   // register the channels and terms so outputs come from flops
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dataChannelOne_r <= 1'b0;
         dataChannelTwo_r <= 1'b0;
         gateTerm_r <= '0;
      end else if (warmRst) begin
         dataChannelOne_r <= 1'b0;
         dataChannelTwo_r <= 1'b0;
         gateTerm_r <= '0;
      end else begin
         dataChannelOne_r <= chanOne;
         dataChannelTwo_r <= chanTwo;
         gateTerm_r <= term_nxt;
      end
   end

   // write address and data are taken independently, in either order
   assign awTake = s_axi_awvalid && awready_r;
   assign wTake = s_axi_wvalid && wready_r;
   assign wrDo = awHeld_r && wHeld_r && !bvalid_r;
   assign wrSel = wrDo && !warmRst && (awAddr_r == SEL_LOW_ADDR); // warm reset drops it
   assign wrGate = wrDo && !warmRst && (awAddr_r == GATE_EN_ADDR);
   assign wrMapped = (awAddr_r == SEL_LOW_ADDR) || (awAddr_r == GATE_EN_ADDR);
   assign awHeld_nxt = (awHeld_r && !wrDo) || awTake;
   assign wHeld_nxt = (wHeld_r && !wrDo) || wTake;
   assign bvalid_nxt = wrDo || (bvalid_r && !s_axi_bready);

   // byte lanes of the enable register
   assign gateEn_nxt = {
      (wStrb_r[LANE1] ? wData_r[15:8] : gateEn_r[15:8]),
      (wStrb_r[LANE0] ? wData_r[7:0] : gateEn_r[7:0])
   };

   // write channel sequencing; new address waits until the response is taken
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= '0;
         wStrb_r <= '0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (warmRst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         awHeld_r <= awHeld_nxt;
         wHeld_r <= wHeld_nxt;
         if (awTake) begin
            awAddr_r <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         awready_r <= !awHeld_nxt && !bvalid_nxt;
         wready_r <= !wHeld_nxt && !bvalid_nxt;
         bvalid_r <= bvalid_nxt;
         if (wrDo) begin
            bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // selectors: only power-up clears them, warm reset leaves them alone
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         selOne_r <= SEL_POR_VALUE;
         selTwo_r <= SEL_POR_VALUE;
      end else if (wrSel && wStrb_r[LANE0]) begin
         selOne_r <= wData_r[CH_ONE_LSB +: SEL_W];
         selTwo_r <= wData_r[CH_TWO_LSB +: SEL_W];
      end
   end

   // gate enables follow the same reset scheme
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gateEn_r <= GATE_EN_RESET;
      end else if (wrGate) begin
         gateEn_r <= gateEn_nxt;
      end
   end

   // read decode; unmapped reads give zero and an error
   assign arTake = s_axi_arvalid && arready_r;
   assign rdSel = s_axi_araddr == SEL_LOW_ADDR;
   assign rdGate = s_axi_araddr == GATE_EN_ADDR;
   assign rdStat = s_axi_araddr == STATUS_ADDR;
   assign rdMapped = rdSel || rdGate || rdStat;
   assign selWord = {24'h000000, 1'b0, selTwo_r, 1'b0, selOne_r};
   assign gateWord = {16'h0000, gateEn_r};
   assign statWord = {candSync_r, 14'h0000, dataChannelTwo_r, dataChannelOne_r};
   assign rdWord = rdSel ? selWord : rdGate ? gateWord : rdStat ? statWord : '0;
   assign rvalid_nxt = arTake || (rvalid_r && !s_axi_rready);

   // read channel: one read at a time, answer one cycle after the take
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (warmRst) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
      end else begin
         arready_r <= !rvalid_nxt;
         rvalid_r <= rvalid_nxt;
         if (arTake) begin
            rdata_r <= rdWord;
            rresp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // bus outputs straight from flops
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // helper logic for the checks below
   logic started_r;
   logic expOne;
   logic expTwo;
   logic selOneHigh;
   logic [SEL_W-1:0] wrFieldOne;
   logic [SEL_W-1:0] wrFieldTwo;
   logic [15:0] expTerms;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         started_r <= 1'b0;
      end else begin
         started_r <= 1'b1;
      end
   end

   assign expOne = candSync_r[selOne_r];
   assign expTwo = candSync_r[4'({1'b0, selTwo_r} + CH_TWO_BASE)];
   assign selOneHigh = {1'b0, selOne_r} >= CH_ONE_HIGH_FIRST;
   assign wrFieldOne = wData_r[CH_ONE_LSB +: SEL_W];
   assign wrFieldTwo = wData_r[CH_TWO_LSB +: SEL_W];
   assign expTerms = {GATE_N{~dataChannelTwo_r, dataChannelTwo_r,
                             ~dataChannelOne_r, dataChannelOne_r}} & gateEn_r;

   sequence selWriteSeq;
      wrSel && wStrb_r[LANE0];
   endsequence

   sequence selReadSeq;
      arTake && rdSel;
   endsequence

   chan_two_route_a: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      started_r && !$past(warmRst) |-> dataChannelTwo_r == $past(expTwo))
      else $error("channel two does not follow selector plus four");

   chan_one_high_a: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      started_r && !$past(warmRst) && $past(selOneHigh) |-> dataChannelOne_r == $past(expOne))
      else $error("channel one wrong for codes two to seven");

   chan_one_low_a: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      started_r && !$past(warmRst) && !$past(selOneHigh)
      |-> dataChannelOne_r == $past(expOne))
      else $error("channel one wrong for codes zero and one");

   unused_bits_zero_a: assert property (
      @(posedge ref_clk) disable iff (!nrst || warmRst)
      selReadSeq |=> rvalid_r && !rdata_r[7] && !rdata_r[3] && rresp_r == RESP_OKAY)
      else $error("unimplemented selector bits read nonzero");

   sel_write_take_a: assert property (
      @(posedge ref_clk) disable iff (!nrst || warmRst)
      selWriteSeq |=> selOne_r == $past(wrFieldOne) && selTwo_r == $past(wrFieldTwo))
      else $error("selector write not stored");

   sel_warm_keep_a: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      warmRst |=> $stable(selOne_r) && $stable(selTwo_r))
      else $error("selectors changed across warm reset");

   gate_term_form_a: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      started_r && !$past(warmRst) |-> gateTerm_r == $past(expTerms))
      else $error("gate terms do not match enabled forms");
endmodule : lcis_input_select

// >>> lcis_pkg.sv
/*
 package for the logic cell input select block: register map, field layout,
 reset values and bus response codes.
 assumes an AXI4-Lite master with 32-bit data and byte addresses.

 // How it works
 // - channel two selector bits 6..4 pick candidate input code plus four.
 // - channel one selector bits 2..0 pick candidate input equal to the code.
 // - bits 7 and 3 ignore writes and always read back zero.
 // - selectors read/write, undefined at power-up, kept across other resets.
 // - each channel offered true and inverted to every gate, each separately enabled.
*/
package lcis_pkg;
   // register byte addresses
   localparam logic [7:0] SEL_LOW_ADDR = 8'h00;
   localparam logic [7:0] GATE_EN_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // selector field layout
   localparam int SEL_W = 3;
   localparam int CH_ONE_LSB = 0;
   localparam int CH_TWO_LSB = 4;
   localparam int CAND_N = 16;
   localparam logic [3:0] CH_ONE_BASE = 4'h0;
   localparam logic [3:0] CH_TWO_BASE = 4'h4;
   localparam logic [3:0] CH_ONE_HIGH_FIRST = 4'h2;

   // power-up value; any value is legal, zero is taken
   localparam logic [2:0] SEL_POR_VALUE = 3'h0;

   // gate enables: per gate {ch2 inv, ch2 true, ch1 inv, ch1 true}
   localparam int GATE_N = 4;
   localparam int TERM_N = 4;
   localparam logic [15:0] GATE_EN_RESET = 16'h0000;

   // status layout
   localparam int STAT_CH_ONE_BIT = 0;
   localparam int STAT_CH_TWO_BIT = 1;
   localparam int STAT_CAND_LSB = 16;

   // write strobe lanes
   localparam int LANE0 = 0;
   localparam int LANE1 = 1;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lcis_pkg

// >>> lcis_chan_if.sv
/*
 carrier between the top and one channel multiplexer: selector code,
 synchronised candidate inputs and the chosen channel.
 assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface lcis_chan_if;
   logic [2:0] sel;
   logic [15:0] cand;
   logic chan;
   modport mux (input sel, input cand, output chan);
   modport user (output sel, output cand, input chan);
endinterface : lcis_chan_if

// >>> lcis_chan_mux.sv
/*
 one eight-way channel multiplexer: picks candidate input BASE plus code.
 assumes candidates are already synchronised; output is combinational.
*/
`timescale 1ns/1ps
module lcis_chan_mux #(
   parameter logic [3:0] BASE = 4'h0
) (
   lcis_chan_if.mux port
);
   logic [3:0] pickIdx;

   // window of eight starts at base; wraps past the top input
   assign pickIdx = 4'(BASE + {1'b0, port.sel});
   assign port.chan = port.cand[pickIdx];
endmodule : lcis_chan_mux

// >>> test_lcis_input_select.sv
/*
 self-checking bench for the logic cell input select block: drives the
 AXI4-Lite slave and the candidate inputs, watches channels and gate terms.
 assumes a 200 MHz ref_clk and that the design holds its own assertions.
*/
`timescale 1ns/1ps
module test_lcis_input_select;
   import lcis_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic warmRst = 1'b0;
   logic [CAND_N-1:0] candidateInput = '0;
   logic [ADDR_W-1:0] awAddr = '0;
   logic awValid = 1'b0;
   logic awReady;
   logic [DATA_W-1:0] wData = '0;
   logic [3:0] wStrb = 4'h0;
   logic wValid = 1'b0;
   logic wReady;
   logic [1:0] bResp;
   logic bValid;
   logic bReady = 1'b0;
   logic [ADDR_W-1:0] arAddr = '0;
   logic arValid = 1'b0;
   logic arReady;
   logic [DATA_W-1:0] rData;
   logic [1:0] rResp;
   logic rValid;
   logic rReady = 1'b0;
   logic dataChannelOne;
   logic dataChannelTwo;
   logic [15:0] gateTerm;
   int errors = 0;
   int tests_run = 0;

   lcis_input_select uut (
      .ref_clk(ref_clk), .nrst(nrst), .warmRst(warmRst), .candidateInput(candidateInput),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .dataChannelOne_r(dataChannelOne),
      .dataChannelTwo_r(dataChannelTwo), .gateTerm_r(gateTerm)
   );

   // free-running clock, 5 ns period
   always #2.5 ref_clk = ~ref_clk;

   // verdict and end of run
   task automatic test_done;
      if (errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, seen);
         errors++;
      end
   endtask : check

   // write: address and data offered together, each dropped once taken;
   // no cycle limit here, only the watchdog ends a hung wait
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      resp = 2'h3;
      @(posedge ref_clk);
      awAddr <= a;
      awValid <= 1'b1;
      wData <= d;
      wStrb <= 4'hf;
      wValid <= 1'b1;
      bReady <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
         if (bReady && bValid) begin
            resp = bResp;
            bReady <= 1'b0;
            break;
         end
      end
   endtask : axi_write

   // read: rready held until the answer is sampled
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      d = '1;
      resp = 2'h3;
      @(posedge ref_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (arValid && arReady) arValid <= 1'b0;
         if (rReady && rValid) begin
            d = rData;
            resp = rResp;
            rReady <= 1'b0;
            break;
         end
      end
   endtask : axi_read

   // pin to channel path is three edges; six leaves room for the gate terms
   task automatic settle;
      repeat (6) @(posedge ref_clk);
   endtask : settle

   // every channel one code, with the picked input alone high and alone low
   task automatic test_channel_one;
      logic [1:0] r;
      for (int c = 0; c < 8; c++) begin
         axi_write(SEL_LOW_ADDR, 32'(c), r);
         candidateInput <= 16'h0001 << c;
         settle();
         check("channel one high", 1, 32'(dataChannelOne));
         candidateInput <= ~(16'h0001 << c);
         settle();
         check("channel one low", 0, 32'(dataChannelOne));
      end
   endtask : test_channel_one

   // every channel two code, offset by four inputs
   task automatic test_channel_two;
      logic [1:0] r;
      for (int c = 0; c < 8; c++) begin
         axi_write(SEL_LOW_ADDR, 32'(c << 4), r);
         candidateInput <= 16'h0010 << c;
         settle();
         check("channel two high", 1, 32'(dataChannelTwo));
         candidateInput <= ~(16'h0010 << c);
         settle();
         check("channel two low", 0, 32'(dataChannelTwo));
      end
   endtask : test_channel_two

   // unimplemented bits dropped on write, zero on read
   task automatic test_reserved_bits;
      logic [1:0] r;
      logic [31:0] d;
      axi_write(SEL_LOW_ADDR, 32'hffffffff, r);
      check("select write resp", 32'(RESP_OKAY), 32'(r));
      axi_read(SEL_LOW_ADDR, d, r);
      check("select all ones", 32'h00000077, d);
      check("select read resp", 32'(RESP_OKAY), 32'(r));
      axi_write(SEL_LOW_ADDR, 32'h00000088, r);
      axi_read(SEL_LOW_ADDR, d, r);
      check("select reserved only", 32'h00000000, d);
   endtask : test_reserved_bits

   // warm reset must leave both selector fields alone
   task automatic test_warm_reset;
      logic [1:0] r;
      logic [31:0] d;
      axi_write(SEL_LOW_ADDR, 32'h00000052, r);
      @(posedge ref_clk);
      warmRst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      warmRst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      axi_read(SEL_LOW_ADDR, d, r);
      check("select after warm reset", 32'h00000052, d);
      candidateInput <= 16'h0204;
      settle();
      check("channel one kept", 1, 32'(dataChannelOne));
      check("channel two kept", 1, 32'(dataChannelTwo));
   endtask : test_warm_reset

   // true and inverted forms per gate, each under its own enable
   task automatic test_gate_terms;
      logic [1:0] r;
      logic [31:0] d;
      axi_write(SEL_LOW_ADDR, 32'h00000000, r);
      candidateInput <= 16'h0001;
      axi_write(GATE_EN_ADDR, 32'h0000ffff, r);
      settle();
      check("terms all enabled", 32'h00009999, 32'(gateTerm));
      axi_write(GATE_EN_ADDR, 32'h00005a3c, r);
      settle();
      check("terms partly enabled", 32'h00001818, 32'(gateTerm));
      axi_read(GATE_EN_ADDR, d, r);
      check("enable readback", 32'h00005a3c, d);
      candidateInput <= 16'h0010;
      settle();
      check("terms swapped inputs", 32'h00004224, 32'(gateTerm));
      axi_read(STATUS_ADDR, d, r);
      check("status resp", 32'(RESP_OKAY), 32'(r));
      check("status word", 32'h00100002, d);
   endtask : test_gate_terms

   // an address outside the map is refused without side effects
   task automatic test_unmapped;
      logic [1:0] r;
      logic [31:0] d;
      axi_write(8'h40, 32'h000000ff, r);
      check("unmapped write resp", 32'(RESP_SLVERR), 32'(r));
      axi_read(8'h40, d, r);
      check("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
      check("unmapped read data", 32'h0, d);
      axi_read(SEL_LOW_ADDR, d, r);
      check("select after unmapped write", 32'h0, d);
   endtask : test_unmapped

   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      test_channel_one();
      test_channel_two();
      test_reserved_bits();
      test_warm_reset();
      test_gate_terms();
      test_unmapped();
      test_done();
   end

   // hang guard, well past the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      test_done();
   end
endmodule : test_lcis_input_select
